/* core/boot_chain_pkg.sv */
package boot_chain_pkg;

  // Register byte address; all printed offsets are word aligned.
  localparam logic [19:0] BOOT_CTRL_ADDR = 20'h1D140;

  // Bit positions, bit 0 being the register's least significant bit.
  localparam int CHAIN_BIT = 31;
  localparam int WIDTH_BIT = 30;
  localparam int STEP_BIT = 29;
  localparam int UNLOCK_BIT = 28;
  localparam int TADDR_HI = 22;
  localparam int TADDR_LO = 16;
  localparam int BOUND_HI = 15;
  localparam int BOUND_LO = 13;
  localparam int OFFS_HI = 12;
  localparam int OFFS_LO = 0;

  localparam logic [31:0] WRITABLE_MASK = 32'hF07FFFFF;
  localparam logic [1:0] PINS_MASK = 2'h3;

  // Reset values of the fields that have no pin source.
  localparam logic RST_CHAIN = 1'h0;
  localparam logic RST_WIDTH = 1'h0;
  localparam logic RST_STEP = 1'h1;
  localparam logic RST_UNLOCK = 1'h0;
  localparam logic [4:0] RST_TADDR_HI = 5'h14;
  localparam logic [2:0] RST_BOUND = 3'h0;
  localparam logic [12:0] RST_OFFS = 13'h0000;

  localparam logic [2:0] BOUND_NEVER = 3'h7;
  localparam logic [2:0] DEV_STEP_MASK = 3'h7;
  localparam logic [7:0] PAGE_WRAP = 8'hFF;
  localparam logic [7:0] RD_COUNT_ZERO = 8'h00;

  typedef struct packed {
    logic chain;
    logic periph_addr_width;
    logic page_select_step_en;
    logic target_addr_lsb_unlock;
    logic [6:0] target_addr;
    logic [2:0] bound;
    logic [12:0] offset;
  } ctrl_t;

  // One request to the bit-level master engine.
  typedef struct packed {
    logic [6:0] dev_addr;
    logic two_byte;
    logic [15:0] periph_addr;
  } addr_phase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_READ = 3'b011,
    ST_DONE = 3'b010
  } load_state_t;

endpackage : boot_chain_pkg

/* core/bound_check.sv */
module bound_check
  import boot_chain_pkg::*;
(
  input wire logic [2:0] code_i,
  input wire logic [15:0] addr_i,
  output logic hit_o
);

  // True when the byte address just reached sits on the selected boundary.
  always_comb begin
    case (code_i)
      3'h0: hit_o = (addr_i[2:0] == 3'h0);
      3'h1: hit_o = (addr_i[4:0] == 5'h00);
      3'h2: hit_o = (addr_i[5:0] == 6'h00);
      3'h3: hit_o = (addr_i[6:0] == 7'h00);
      3'h4: hit_o = (addr_i[7:0] == 8'h00);
      3'h5: hit_o = (addr_i[8:0] == 9'h000);
      3'h6: hit_o = (addr_i[9:0] == 10'h000);
      default: hit_o = 1'b0;
    endcase
  end

endmodule : bound_check

/* core/boot_chain_ctrl.sv */
// Function
// R1 - After reset a boot load starts, steered by the control register reset contents.
// R2 - During load, fetched data may overwrite the control register and redirect loading.
// R3 - After load completes the register stays read/write but steers nothing.
// R4 - Chain happens only with chain bit set and remaining load count zero.
// R5 - Other field writes store but act only when the chain bit is set; here the boundary code acts at once.
// R6 - Width bit 0 sends one byte from offset low 5 bits, 1 sends two bytes.
// R7 - Two-byte addresses go out most significant byte first.
// R8 - Page wrap with stepping on increments low 3 device bits, then re-addresses.
// R9 - Page stepping applies only with one-byte addressing.
// R10 - Page step enable resets to 1; 0 suppresses stepping.
// R11 - Target address copied to a working address at start and chain; copy increments.
// R12 - Two lowest target bits change only when the same write sets unlock.
// R13 - Two lowest target bits are caught from board select pins at reset release.
// R14 - Boundary code selects 8 to 1024 bytes, 111 means never re-address.
// R15 - Reserved bits read zero and ignore writes.
//
// Decided for this implementation: the strobed register port.
module boot_chain_ctrl
  import boot_chain_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] board_select_pins_i,
  input wire logic [19:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic load_wr_i,
  input wire logic [31:0] load_wdata_i,
  input wire logic [7:0] load_count_i,
  input wire logic load_end_i,
  input wire logic eng_ready_i,
  input wire logic byte_valid_i,
  output logic addr_req_o,
  output addr_phase_t addr_phase_o,
  output logic byte_ready_o,
  output logic [6:0] work_addr_o,
  output logic loading_o
);

  logic [1:0] pins_meta_r;
  logic [1:0] pins_sync_r;
  logic pins_caught_r;
  logic pins_caught_nxt;
  ctrl_t ctrl_r;
  ctrl_t ctrl_nxt;
  load_state_t state_r;
  load_state_t state_nxt;
  logic [6:0] work_addr_r;
  logic [6:0] work_addr_nxt;
  logic [15:0] paddr_r;
  logic [15:0] paddr_nxt;
  logic width_r;
  logic width_nxt;
  logic step_en_r;
  logic step_en_nxt;
  logic addr_req_r;
  logic addr_req_nxt;
  addr_phase_t phase_r;
  addr_phase_t phase_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] paddr_inc;
  logic bound_hit;
  logic wrap_hit;
  logic sel_hit;
  logic any_wr;
  logic [31:0] wr_data;
  logic chain_now;
  ctrl_t wr_view;
  logic [1:0] sync_fill_r;
  logic byte_ready_nxt;
  logic loading_nxt;

  // The stored struct is narrower than the register word, so fields are placed one by one at their bit positions.
  // Reserved bits come back as zero.
  function automatic logic [31:0] pack_ctrl(input ctrl_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[CHAIN_BIT] = c.chain;
    w[WIDTH_BIT] = c.periph_addr_width;
    w[STEP_BIT] = c.page_select_step_en;
    w[UNLOCK_BIT] = c.target_addr_lsb_unlock;
    w[TADDR_HI:TADDR_LO] = c.target_addr;
    w[BOUND_HI:BOUND_LO] = c.bound;
    w[OFFS_HI:OFFS_LO] = c.offset;
    return w;
  endfunction : pack_ctrl

  // Picks the fields out of a register word; anything at a reserved position is dropped.
  function automatic ctrl_t unpack_ctrl(input logic [31:0] w);
    ctrl_t c;
    c.chain = w[CHAIN_BIT];
    c.periph_addr_width = w[WIDTH_BIT];
    c.page_select_step_en = w[STEP_BIT];
    c.target_addr_lsb_unlock = w[UNLOCK_BIT];
    c.target_addr = w[TADDR_HI:TADDR_LO];
    c.bound = w[BOUND_HI:BOUND_LO];
    c.offset = w[OFFS_HI:OFFS_LO];
    return c;
  endfunction : unpack_ctrl

  // Pins come from outside the clock domain.
  // The fill shift register marks when the second flop holds a real pin sample, so the catch never sees
  // the reset value of the synchroniser.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pins_meta_r <= 2'h0;
      pins_sync_r <= 2'h0;
      sync_fill_r <= 2'h0;
    end else begin
      pins_meta_r <= board_select_pins_i;
      pins_sync_r <= pins_meta_r;
      sync_fill_r <= {sync_fill_r[0], 1'b1};
    end
  end

  assign sel_hit = (reg_addr_i == BOOT_CTRL_ADDR);
  // The boot stream writes through its own port only while loading.
  assign any_wr = (reg_wr_i && sel_hit) || (load_wr_i && state_r != ST_IDLE && state_r != ST_DONE); // see R2
  assign wr_data = (load_wr_i && state_r != ST_DONE) ? load_wdata_i : reg_wdata_i;
  assign wr_view = unpack_ctrl(wr_data & WRITABLE_MASK); // see R15

  // Register storage.
  always_comb begin
    ctrl_nxt = ctrl_r;
    pins_caught_nxt = pins_caught_r | sync_fill_r[1];
    if (!pins_caught_r) begin
      // Register writes are not taken before the pins have been caught.
      if (sync_fill_r[1]) begin
        ctrl_nxt.target_addr[1:0] = pins_sync_r & PINS_MASK; // see R13
      end
    end else if (any_wr) begin
      ctrl_nxt.chain = wr_view.chain;
      ctrl_nxt.periph_addr_width = wr_view.periph_addr_width;
      ctrl_nxt.page_select_step_en = wr_view.page_select_step_en;
      ctrl_nxt.target_addr_lsb_unlock = wr_view.target_addr_lsb_unlock;
      ctrl_nxt.target_addr[6:2] = wr_view.target_addr[6:2];
      if (wr_view.target_addr_lsb_unlock) begin
        ctrl_nxt.target_addr[1:0] = wr_view.target_addr[1:0]; // see R12
      end
      ctrl_nxt.bound = wr_view.bound;
      ctrl_nxt.offset = wr_view.offset;
    end
    if (chain_now) begin
      ctrl_nxt.chain = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pins_caught_r <= 1'b0;
      ctrl_r.chain <= RST_CHAIN;
      ctrl_r.periph_addr_width <= RST_WIDTH;
      ctrl_r.page_select_step_en <= RST_STEP; // see R10
      ctrl_r.target_addr_lsb_unlock <= RST_UNLOCK; // see R12
      ctrl_r.target_addr <= {RST_TADDR_HI, 2'h0};
      ctrl_r.bound <= RST_BOUND;
      ctrl_r.offset <= RST_OFFS;
    end else begin
      pins_caught_r <= pins_caught_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // Chain only on the final entry of the current EEPROM.
  assign chain_now = (state_r == ST_READ) && ctrl_r.chain && (load_count_i == RD_COUNT_ZERO); // see R4

  assign paddr_inc = paddr_r + 16'h0001;
  // One-byte page wrap: offset low byte rolls over.
  assign wrap_hit = !width_r && (paddr_r[7:0] == PAGE_WRAP);

  bound_check u_bound (
    .code_i(ctrl_r.bound), // see R14
    .addr_i(paddr_inc),
    .hit_o(bound_hit)
  );

  // Load sequencer.
  always_comb begin
    state_nxt = state_r;
    work_addr_nxt = work_addr_r;
    paddr_nxt = paddr_r;
    width_nxt = width_r;
    step_en_nxt = step_en_r;
    addr_req_nxt = 1'b0;
    phase_nxt = phase_r;
    case (state_r)
      ST_IDLE: begin
        if (pins_caught_r) begin
          // Start from the reset contents plus the caught pins.
          work_addr_nxt = ctrl_r.target_addr; // see R1 see R11
          paddr_nxt = {ctrl_r.offset, 3'h0};
          width_nxt = ctrl_r.periph_addr_width;
          step_en_nxt = ctrl_r.page_select_step_en;
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        addr_req_nxt = 1'b1;
        phase_nxt.dev_addr = work_addr_r;
        phase_nxt.two_byte = width_r; // see R6
        // Upper byte first on the wire for two-byte form.
        phase_nxt.periph_addr = width_r ? paddr_r : {8'h00, paddr_r[7:0]}; // see R7
        if (addr_req_r && eng_ready_i) begin
          addr_req_nxt = 1'b0;
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (load_end_i && !chain_now) begin
          state_nxt = ST_DONE; // see R3
        end else if (chain_now) begin
          // Pending field writes other than the boundary code take effect only here.
          work_addr_nxt = ctrl_r.target_addr; // see R5 see R11
          paddr_nxt = {ctrl_r.offset, 3'h0};
          width_nxt = ctrl_r.periph_addr_width;
          step_en_nxt = ctrl_r.page_select_step_en;
          state_nxt = ST_ADDR;
        end else if (byte_valid_i) begin
          paddr_nxt = width_r ? paddr_inc : {8'h00, paddr_inc[7:0]};
          if (wrap_hit && step_en_r) begin
            work_addr_nxt = {work_addr_r[6:3], (work_addr_r[2:0] + 3'h1) & DEV_STEP_MASK}; // see R8 see R9
            state_nxt = ST_ADDR;
          end else if (bound_hit) begin
            state_nxt = ST_ADDR;
          end
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      work_addr_r <= 7'h00;
      paddr_r <= 16'h0000;
      width_r <= 1'b0;
      step_en_r <= 1'b0;
      addr_req_r <= 1'b0;
      phase_r <= '0;
    end else begin
      state_r <= state_nxt;
      work_addr_r <= work_addr_nxt;
      paddr_r <= paddr_nxt;
      width_r <= width_nxt;
      step_en_r <= step_en_nxt;
      addr_req_r <= addr_req_nxt;
      phase_r <= phase_nxt;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd_i && sel_hit) begin
      rdata_nxt = pack_ctrl(ctrl_r) & WRITABLE_MASK; // see R15
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  logic byte_ready_r;
  logic loading_r;

  // Status outputs follow the next state so that they line up with the registered state.
  always_comb begin
    byte_ready_nxt = (state_nxt == ST_READ);
    loading_nxt = (state_nxt != ST_IDLE) && (state_nxt != ST_DONE); // see R3
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      byte_ready_r <= 1'b0;
      loading_r <= 1'b0;
    end else begin
      byte_ready_r <= byte_ready_nxt;
      loading_r <= loading_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign addr_req_o = addr_req_r;
  assign addr_phase_o = phase_r;
  assign byte_ready_o = byte_ready_r;
  assign work_addr_o = work_addr_r;
  assign loading_o = loading_r;

endmodule : boot_chain_ctrl

/* verif/boot_chain_ctrl_sva.sv */
module boot_chain_ctrl_sva
  import boot_chain_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic eng_ready_i,
  input wire logic addr_req_o,
  input wire addr_phase_t addr_phase_o,
  input wire logic byte_ready_o,
  input wire logic [6:0] work_addr_o,
  input wire logic loading_o
);
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  req_hold_a: assert property (addr_req_o && !eng_ready_i |=> addr_req_o) else $error("request dropped");
  req_take_a: assert property (addr_req_o && eng_ready_i |=> !addr_req_o && byte_ready_o)
    else $error("request not taken");
  one_byte_fmt_a: assert property (addr_req_o && !addr_phase_o.two_byte |-> addr_phase_o.periph_addr[15:8] == 8'h00)
    else $error("one byte address too wide");
  low_zero_a: assert property (addr_req_o |-> addr_phase_o.periph_addr[2:0] == 3'h0) else $error("low bits set");
  dev_copy_a: assert property (addr_req_o |-> addr_phase_o.dev_addr == work_addr_o) else $error("device addr");
  done_quiet_a: assert property (!loading_o |-> !addr_req_o && !byte_ready_o) else $error("active after load");
  done_final_a: assert property ($fell(loading_o) |=> !loading_o [*8]) else $error("load restarted");
  reserved_zero_a: assert property (reg_rdata_o[27:23] == 5'h00) else $error("reserved bits set");
  step_phase_a: assert property ($changed(work_addr_o) |-> ##[0:4] addr_req_o) else $error("no new phase");
endmodule : boot_chain_ctrl_sva

bind boot_chain_ctrl boot_chain_ctrl_sva chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_rdata_o(reg_rdata_o),
  .eng_ready_i(eng_ready_i), .addr_req_o(addr_req_o), .addr_phase_o(addr_phase_o), .byte_ready_o(byte_ready_o),
  .work_addr_o(work_addr_o), .loading_o(loading_o));

/* verif/engine_model.sv */
module engine_model #(
  parameter int DELAY = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic addr_req_i,
  input wire logic byte_ready_i,
  input wire logic stall_i,
  output logic eng_ready_o,
  output logic byte_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  // Accepts an address phase DELAY+1 cycles after it first sees the request, then reads one byte every other cycle.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !addr_req_i || eng_ready_o) begin
      wait_r <= 4'h0;
      eng_ready_o <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
      eng_ready_o <= (32'(wait_r) >= DELAY);
    end
    byte_valid_o <= rst_n_i && byte_ready_i && !stall_i && !byte_valid_o;
  end
endmodule : engine_model

/* verif/i2c_boot_chain_control_bench.sv */
module i2c_boot_chain_control_bench
  import boot_chain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] RA = BOOT_CTRL_ADDR;
  logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, load_wr_i, load_end_i, stall, eng_ready_i, byte_valid_i;
  logic addr_req_o, byte_ready_o, loading_o;
  logic [1:0] pins;
  logic [19:0] reg_addr_i;
  logic [31:0] reg_wdata_i, load_wdata_i, reg_rdata_o;
  logic [7:0] load_count_i;
  logic [6:0] work_addr_o;
  addr_phase_t addr_phase_o;
  int bad_count, checks;
  boot_chain_ctrl dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .board_select_pins_i(pins), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .load_wr_i(load_wr_i), .load_wdata_i(load_wdata_i), .load_count_i(load_count_i), .load_end_i(load_end_i),
    .eng_ready_i(eng_ready_i), .byte_valid_i(byte_valid_i), .addr_req_o(addr_req_o), .addr_phase_o(addr_phase_o),
    .byte_ready_o(byte_ready_o), .work_addr_o(work_addr_o), .loading_o(loading_o));
  engine_model eng (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_req_i(addr_req_o), .byte_ready_i(byte_ready_o),
    .stall_i(stall), .eng_ready_o(eng_ready_i), .byte_valid_o(byte_valid_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : reg_rd
  task automatic load_wr(input logic [31:0] d);
    @(posedge clock_i);
    load_wdata_i <= d;
    load_wr_i <= 1'b1;
    @(posedge clock_i);
    load_wr_i <= 1'b0;
  endtask : load_wr
  // Waits mid-cycle for an address phase that the engine is about to take.
  task automatic phase(input logic [6:0] dev, input logic two, input logic [15:0] pa);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (!(addr_req_o === 1'b1 && eng_ready_i === 1'b1) && n < 400);
    chk({8'h00, addr_phase_o}, {8'h00, dev, two, pa});
  endtask : phase
  initial begin
    #500000;
    bad_count++;
    end_of_test;
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, load_wr_i, load_end_i, stall} = 6'h00;
    pins = 2'h2;
    reg_addr_i = RA;
    reg_wdata_i = 32'h0;
    load_wdata_i = 32'h0;
    load_count_i = 8'h00;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    phase(7'h52, 1'b0, 16'h0000);
    phase(7'h52, 1'b0, 16'h0008);
    stall = 1'b1;
    reg_rd(RA, 32'h20520000);
    $display("test boot done");
    load_count_i <= 8'h05;
    load_wr(32'hD053E123);
    repeat (20) @(posedge clock_i);
    chk({25'h0, work_addr_o}, 32'h52);
    load_count_i <= 8'h00;
    phase(7'h53, 1'b1, 16'h0918);
    reg_rd(RA, 32'h5053E123);
    load_wr(32'hB050E01F);
    phase(7'h50, 1'b0, 16'h00F8);
    stall = 1'b0;
    phase(7'h51, 1'b0, 16'h0000);
    stall = 1'b1;
    reg_rd(RA, 32'h3050E01F);
    $display("test chain done");
    @(posedge clock_i);
    load_end_i <= 1'b1;
    @(posedge clock_i);
    load_end_i <= 1'b0;
    reg_wr(RA, 32'h80570000);
    reg_rd(RA, 32'h80540000);
    repeat (20) @(posedge clock_i);
    chk({30'h0, addr_req_o, loading_o}, 32'h0);
    reg_wr(RA, 32'hFFFFFFFF);
    reg_rd(RA, 32'hF07FFFFF);
    reg_rd(20'h1D144, 32'h0);
    $display("test after_load done");
    end_of_test;
  end
endmodule : i2c_boot_chain_control_bench
